// ===== mlpc_defines.svh
`ifndef MLPC_DEFINES_SVH
`define MLPC_DEFINES_SVH

// ==========================================================================
// register offsets
`define MLPC_OFS_CTRL_STATUS 8'h00
`define MLPC_OFS_IDLE_TIME 8'h04
`define MLPC_OFS_WAKE_TIME 8'h08

// ==========================================================================
// control and status field positions
`define MLPC_BIT_AUTO 0
`define MLPC_BIT_REQ_CTRL 1
`define MLPC_BIT_HOLD_CTRL 2
`define MLPC_BIT_REQ_NOW 8
`define MLPC_BIT_HOLD_NOW 9
`define MLPC_BIT_TX_ACTIVE_NOW 10
`define MLPC_BIT_TX_FIFO_DATA 11
`define MLPC_BIT_RX_IDLE_NOW 12
`define MLPC_BIT_REQ_LATCHED 16
`define MLPC_BIT_HOLD_LATCHED 17
`define MLPC_BIT_TX_ACTIVE_LATCHED 18
`define MLPC_BIT_RX_IDLE_LATCHED 20

// ==========================================================================
// reset values
`define MLPC_RST_CTRL 3'h0
`define MLPC_RST_TIME 32'h0000_0000
`define MLPC_RST_LATCHED 4'h0

// ==========================================================================
// timing: idle time counts in units of this many system clocks
`define MLPC_IDLE_UNIT_CYCLES 32
`define MLPC_IDLE_UNIT_LAST 5'h1f

`endif

// ===== mlpc_eee_ctrl.sv
// Added by the designer: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "mlpc_defines.svh"

// How it works
// - receive low-power-idle sets bit 20; a read of the register clears it
// - MAC transmitting sets bit 18; cleared by a register read
// - internal transmit hold sets bit 17; cleared by a register read
// - internal low-power request sets bit 16; cleared by a register read
// - bit 12 follows receive low-power-idle detection live
// - bit 11 follows transmit FIFO not empty live
// - bit 10 follows MAC transmitting live
// - bit 9 shows the MAC stopped: hold, low-power idle, or wake waiting
// - bit 8 shows the internal low-power request: manual or idle expiry
// - hold bit lets the current frame end, then stops fetching
// - request alone drains all queued frames, then idles, then shows status
// - no new frames are served while in low-power idle
// - hold with request stops after the current frame, queue not drained
// - the request bit is accepted at any time, even in automatic mode
// - automatic mode enters low-power idle after configured idle time
// - without automatic mode, low-power idle is never entered alone
// - idle time is count minus one, in 32-clock units; zero disables
// - wake time is count minus one, in clocks; zero disables
module mlpc_eee_ctrl (
    // clock and reset
    input wire logic clk,
    input wire logic srst,

    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,

    // from the MAC transmit path
    input wire logic tx_fifo_has_data,
    input wire logic tx_active_now,

    // from the reconciliation sublayer receive side
    input wire logic rx_idle_seen_now,

    // to the MAC transmit path and reconciliation sublayer
    output logic tx_hold_now,
    output logic low_power_request_now,
    output logic tx_send_low_power_idle
);

    // ======================================================================
    // software visible state
    logic auto_low_power_enable;
    logic low_power_request_ctrl;
    logic tx_hold_ctrl;
    logic [31:0] idle_before_sleep_time;
    logic [31:0] wake_to_transmit_time;

    logic rx_idle_seen_latched;
    logic tx_active_latched;
    logic tx_hold_latched;
    logic low_power_request_latched;

    // ======================================================================
    // sequencing state
    mlpc_pkg::mlpc_state_t state;
    mlpc_pkg::mlpc_state_t next_state;

    logic [4:0] idle_prescale;
    logic idle_unit_tick;
    logic idle_run;
    logic idle_expired;
    logic wake_run;
    logic wake_expired;

    // ======================================================================
    // register decode
    wire sel_ctrl = (reg_addr == `MLPC_OFS_CTRL_STATUS);
    wire sel_idle = (reg_addr == `MLPC_OFS_IDLE_TIME);
    wire sel_wake = (reg_addr == `MLPC_OFS_WAKE_TIME);

    wire wr_ctrl = reg_write && sel_ctrl;
    wire wr_idle = reg_write && sel_idle;
    wire wr_wake = reg_write && sel_wake;

    // a read of the control word is what clears the latched bits
    wire clear_read = reg_read && sel_ctrl;

    // ======================================================================
    // transmit is idle only with nothing moving and nothing waiting
    wire tx_quiet = !tx_active_now && !tx_fifo_has_data;

    // drain ends when the wire is free; with hold set the queue is left
    wire drain_done = !tx_active_now && (tx_hold_ctrl || !tx_fifo_has_data);

    // zero in either timer register turns that timer off
    wire idle_timer_on = (idle_before_sleep_time != `MLPC_RST_TIME);
    wire wake_timer_on = (wake_to_transmit_time != `MLPC_RST_TIME);

    // automatic entry needs the mode bit, a live timer and its expiry
    wire auto_sleep = auto_low_power_enable && idle_timer_on && idle_expired;

    // leave low power once nothing keeps it: request gone, auto released
    wire stay_low = low_power_request_ctrl
                    || (auto_low_power_enable && !tx_fifo_has_data);

    wire in_low_power = (state == mlpc_pkg::MLPC_LOW_POWER);
    wire in_wake = (state == mlpc_pkg::MLPC_WAKE);

    // ======================================================================
    // control bits
    always_ff @(posedge clk) begin
        if (srst) begin
            {tx_hold_ctrl, low_power_request_ctrl, auto_low_power_enable}
                <= `MLPC_RST_CTRL;
        end else if (wr_ctrl) begin
            auto_low_power_enable <= reg_wdata[`MLPC_BIT_AUTO];
            low_power_request_ctrl <= reg_wdata[`MLPC_BIT_REQ_CTRL];
            tx_hold_ctrl <= reg_wdata[`MLPC_BIT_HOLD_CTRL];
        end
    end

    // ======================================================================
    // timer registers
    always_ff @(posedge clk) begin
        if (srst) begin
            idle_before_sleep_time <= `MLPC_RST_TIME;
        end else if (wr_idle) begin
            idle_before_sleep_time <= reg_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            wake_to_transmit_time <= `MLPC_RST_TIME;
        end else if (wr_wake) begin
            wake_to_transmit_time <= reg_wdata;
        end
    end

    // ======================================================================
    // latched status: set wins over the clearing read
    wire next_rx_idle_latched = rx_idle_seen_now
                                || (rx_idle_seen_latched && !clear_read);
    wire next_tx_active_latched = tx_active_now
                                  || (tx_active_latched && !clear_read);
    wire next_hold_latched = tx_hold_now
                             || (tx_hold_latched && !clear_read);
    wire next_req_latched = low_power_request_now
                            || (low_power_request_latched && !clear_read);

    always_ff @(posedge clk) begin
        if (srst) begin
            {rx_idle_seen_latched, tx_active_latched,
             tx_hold_latched, low_power_request_latched} <= `MLPC_RST_LATCHED;
        end else begin
            rx_idle_seen_latched <= next_rx_idle_latched;
            tx_active_latched <= next_tx_active_latched;
            tx_hold_latched <= next_hold_latched;
            low_power_request_latched <= next_req_latched;
        end
    end

    // ======================================================================
    // idle timer: counts whole 32-clock units of a quiet transmitter
    assign idle_run = auto_low_power_enable && idle_timer_on && tx_quiet
                      && (state == mlpc_pkg::MLPC_NORMAL);
    assign idle_unit_tick = (idle_prescale == `MLPC_IDLE_UNIT_LAST);

    always_ff @(posedge clk) begin
        if (srst || !idle_run) begin
            idle_prescale <= 5'h00;
        end else begin
            idle_prescale <= idle_prescale + 5'h01;
        end
    end

    // expires after the register value plus one units
    mlpc_timer u_idle_timer (
        .clk(clk),
        .srst(srst),
        .run(idle_run),
        .tick(idle_unit_tick),
        .limit(idle_before_sleep_time),
        .expired(idle_expired)
    );

    // ======================================================================
    // wake timer: runs from the end of low power until sending resumes
    assign wake_run = in_wake && wake_timer_on;

    mlpc_timer u_wake_timer (
        .clk(clk),
        .srst(srst),
        .run(wake_run),
        .tick(1'b1),
        .limit(wake_to_transmit_time),
        .expired(wake_expired)
    );

    // ======================================================================
    // power state sequencing
    always_comb begin
        next_state = state;
        unique case (state)
            mlpc_pkg::MLPC_NORMAL: begin
                if (low_power_request_ctrl) begin
                    next_state = mlpc_pkg::MLPC_DRAIN;
                end else if (auto_sleep) begin
                    next_state = mlpc_pkg::MLPC_LOW_POWER;
                end
            end
            mlpc_pkg::MLPC_DRAIN: begin
                if (!low_power_request_ctrl) begin
                    next_state = mlpc_pkg::MLPC_NORMAL;
                end else if (drain_done) begin
                    next_state = mlpc_pkg::MLPC_LOW_POWER;
                end
            end
            mlpc_pkg::MLPC_LOW_POWER: begin
                if (!stay_low) begin
                    next_state = mlpc_pkg::MLPC_WAKE;
                end
            end
            mlpc_pkg::MLPC_WAKE: begin
                if (low_power_request_ctrl) begin
                    next_state = mlpc_pkg::MLPC_DRAIN;
                end else if (!wake_timer_on || wake_expired) begin
                    next_state = mlpc_pkg::MLPC_NORMAL;
                end
            end
            default: begin
                next_state = mlpc_pkg::MLPC_NORMAL;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state <= mlpc_pkg::MLPC_NORMAL;
        end else begin
            state <= next_state;
        end
    end

    // ======================================================================
    // signals to the MAC; hold is taken by the MAC at a frame boundary,
    // so a frame already on the wire always completes
    always_ff @(posedge clk) begin
        if (srst) begin
            tx_hold_now <= 1'b0;
            low_power_request_now <= 1'b0;
            tx_send_low_power_idle <= 1'b0;
        end else begin
            tx_hold_now <= tx_hold_ctrl
                           || (next_state == mlpc_pkg::MLPC_LOW_POWER)
                           || (next_state == mlpc_pkg::MLPC_WAKE);
            low_power_request_now <=
                (next_state == mlpc_pkg::MLPC_LOW_POWER);
            tx_send_low_power_idle <=
                (next_state == mlpc_pkg::MLPC_LOW_POWER);
        end
    end

    // ======================================================================
    // read data: one cycle after the strobe, zero elsewhere
    logic [31:0] ctrl_word;

    always_comb begin
        ctrl_word = 32'h0000_0000;
        ctrl_word[`MLPC_BIT_AUTO] = auto_low_power_enable;
        ctrl_word[`MLPC_BIT_REQ_CTRL] = low_power_request_ctrl;
        ctrl_word[`MLPC_BIT_HOLD_CTRL] = tx_hold_ctrl;
        ctrl_word[`MLPC_BIT_REQ_NOW] = low_power_request_now;
        ctrl_word[`MLPC_BIT_HOLD_NOW] = tx_hold_now;
        ctrl_word[`MLPC_BIT_TX_ACTIVE_NOW] = tx_active_now;
        ctrl_word[`MLPC_BIT_TX_FIFO_DATA] = tx_fifo_has_data;
        ctrl_word[`MLPC_BIT_RX_IDLE_NOW] = rx_idle_seen_now;
        ctrl_word[`MLPC_BIT_REQ_LATCHED] = low_power_request_latched;
        ctrl_word[`MLPC_BIT_HOLD_LATCHED] = tx_hold_latched;
        ctrl_word[`MLPC_BIT_TX_ACTIVE_LATCHED] = tx_active_latched;
        ctrl_word[`MLPC_BIT_RX_IDLE_LATCHED] = rx_idle_seen_latched;
    end

    wire [31:0] read_mux = sel_ctrl ? ctrl_word
                         : sel_idle ? idle_before_sleep_time
                         : sel_wake ? wake_to_transmit_time
                         : 32'h0000_0000;

    always_ff @(posedge clk) begin
        if (srst) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_read) begin
            reg_rdata <= read_mux;
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

endmodule

// ===== mlpc_eee_ctrl_asserts.sv
`timescale 1ns/1ps
`include "mlpc_defines.svh"

// ==========================================================================
// port checker for the low-power-idle controller
module mlpc_eee_ctrl_asserts (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [31:0] reg_rdata,
    // mac side
    input wire logic tx_fifo_has_data,
    input wire logic tx_active_now,
    input wire logic rx_idle_seen_now,
    input wire logic tx_hold_now,
    input wire logic low_power_request_now,
    input wire logic tx_send_low_power_idle
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    wire logic rd0 = reg_read && reg_addr == `MLPC_OFS_CTRL_STATUS;

    a_idle_mirror: assert property (
        tx_send_low_power_idle == low_power_request_now)
        else $error("idle sequence differs from request");
    a_reserved_zero: assert property (
        rd0 |=> (reg_rdata & 32'hffe8_e0f8) == 32'h0000_0000)
        else $error("reserved bit read as one");
    a_live_bits: assert property (rd0 |=> reg_rdata[12:10] ==
        $past({rx_idle_seen_now, tx_fifo_has_data, tx_active_now}))
        else $error("live status bits wrong");
    a_now_bits: assert property (rd0 |=> reg_rdata[9:8] ==
        $past({tx_hold_now, low_power_request_now}))
        else $error("request or hold status wrong");
    a_rx_latch: assert property (
        rx_idle_seen_now ##1 rd0 |=> reg_rdata[20])
        else $error("receive idle not latched");
    a_rx_clear: assert property (
        (rd0 && !rx_idle_seen_now) [*2] |=> !reg_rdata[20])
        else $error("receive idle latch not cleared");
    a_busy_latch: assert property (
        tx_active_now ##1 rd0 |=> reg_rdata[18])
        else $error("transmit busy not latched");
    a_hold_latch: assert property (
        tx_hold_now ##1 rd0 |=> reg_rdata[17])
        else $error("hold not latched");
    a_req_latch: assert property (
        low_power_request_now ##1 rd0 |=> reg_rdata[16])
        else $error("request not latched");
    a_read_keep: assert property (
        rd0 && tx_active_now ##1 rd0 |=> reg_rdata[18])
        else $error("latch lost in clearing read");
    a_sleep_hold: assert property (
        low_power_request_now |-> tx_hold_now)
        else $error("frames allowed in low power");

    c_sleep: cover property ($rose(low_power_request_now));
    c_wake: cover property ($fell(low_power_request_now) ##1 tx_hold_now);
    c_rx_read: cover property (rd0 ##1 reg_rdata[20]);
endmodule

bind mlpc_eee_ctrl mlpc_eee_ctrl_asserts u_chk (.clk(clk), .srst(srst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata),
    .tx_fifo_has_data(tx_fifo_has_data), .tx_active_now(tx_active_now),
    .rx_idle_seen_now(rx_idle_seen_now), .tx_hold_now(tx_hold_now),
    .low_power_request_now(low_power_request_now),
    .tx_send_low_power_idle(tx_send_low_power_idle));

// ===== mlpc_mac_model.sv
`timescale 1ns/1ps

// ==========================================================================
// mac transmit queue and phy receive side, behavioural
module mlpc_mac_model #(
    parameter int FRAME_LEN = 6
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // from the bench
    input wire logic push,
    input wire logic rx_lpi,
    // from the controller
    input wire logic tx_hold_now,
    // to the controller
    output logic tx_fifo_has_data,
    output logic tx_active_now,
    output logic rx_idle_seen_now,
    output int sent
);
    int queued;
    int left;
    // a frame in flight always runs to its end; only fetching stops
    wire logic start = left == 0 && queued != 0 && !tx_hold_now;
    assign tx_fifo_has_data = queued != 0;
    assign tx_active_now = left != 0;
    assign rx_idle_seen_now = rx_lpi;

    always_ff @(posedge clk) begin
        if (srst) begin
            queued <= 0;
            left <= 0;
            sent <= 0;
        end else begin
            queued <= queued + int'(push) - int'(start);
            if (start) left <= FRAME_LEN;
            else if (left != 0) left <= left - 1;
            if (left == 1) sent <= sent + 1;
        end
    end
endmodule

// ===== mlpc_pkg.sv
package mlpc_pkg;

    // ======================================================================
    // transmit power state
    typedef enum logic [2:0] {
        MLPC_NORMAL = 3'h0,
        MLPC_DRAIN = 3'h1,
        MLPC_LOW_POWER = 3'h2,
        MLPC_WAKE = 3'h3
    } mlpc_state_t;

endpackage

// ===== mlpc_tb.sv
`timescale 1ns/1ps
`include "mlpc_defines.svh"

// ==========================================================================
// bench top
module testbench;
    logic clk, srst, reg_write, reg_read, push, rx_lpi;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic fifo, act, rxs, hold, lpr, lpi;
    int sent, s0, n, fails, n_checks, cycles;
    logic [31:0] d;

    mlpc_eee_ctrl dut (.clk(clk), .srst(srst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .tx_fifo_has_data(fifo), .tx_active_now(act),
        .rx_idle_seen_now(rxs), .tx_hold_now(hold),
        .low_power_request_now(lpr), .tx_send_low_power_idle(lpi));
    mlpc_mac_model mac (.clk(clk), .srst(srst), .push(push), .rx_lpi(rx_lpi),
        .tx_hold_now(hold), .tx_fifo_has_data(fifo), .tx_active_now(act),
        .rx_idle_seen_now(rxs), .sent(sent));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // ======================================================================
    // bus and check helpers
    task automatic chk(input bit ok, input string m);
        n_checks++;
        if (!ok) begin
            fails++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic wait_lp(input logic v);
        n = 0;
        while (lpr !== v && n < 400) begin
            @(posedge clk);
            #1 n++;
        end
    endtask
    task automatic queue(input int k);
        @(posedge clk);
        push <= 1'b1;
        repeat (k) @(posedge clk);
        push <= 1'b0;
    endtask

    // ======================================================================
    // scenarios
    task automatic t_regs();
        wr(`MLPC_OFS_CTRL_STATUS, 32'hffff_fff8);
        rd(`MLPC_OFS_CTRL_STATUS);
        chk(d === 32'h0000_0000, "reserved bits stored");
        wr(`MLPC_OFS_WAKE_TIME, 32'h0000_0005);
        rd(`MLPC_OFS_WAKE_TIME);
        chk(d === 32'h0000_0005, "wake time readback");
        wr(8'h0c, 32'h1234_5678);
        rd(8'h0c);
        chk(d === 32'h0000_0000, "unmapped read not zero");
        $display("test regs done");
    endtask
    task automatic t_rx();
        @(posedge clk) rx_lpi <= 1'b1;
        rd(`MLPC_OFS_CTRL_STATUS);
        chk(d[12] === 1'b1 && d[20] === 1'b1, "receive idle seen");
        @(posedge clk) rx_lpi <= 1'b0;
        rd(`MLPC_OFS_CTRL_STATUS);
        chk(d[12] === 1'b0 && d[20] === 1'b1, "latch kept");
        // two reads back to back; the second must see the cleared latch
        @(posedge clk);
        reg_addr <= `MLPC_OFS_CTRL_STATUS;
        reg_read <= 1'b1;
        @(posedge clk);
        @(posedge clk);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
        chk(d[20] === 1'b0 && d[12] === 1'b0, "latch not cleared");
        $display("test rx done");
    endtask
    task automatic t_drain();
        s0 = sent;
        queue(3);
        wr(`MLPC_OFS_CTRL_STATUS, 32'h0000_0002);
        wait_lp(1'b1);
        chk(lpr === 1'b1 && sent - s0 == 3 && fifo === 1'b0,
            "queue not drained");
        rd(`MLPC_OFS_CTRL_STATUS);
        chk(d[9:8] === 2'h3 && d[18:16] === 3'h7,
            "status bits");
        queue(1);
        repeat (20) @(posedge clk);
        chk(sent - s0 == 3 && act === 1'b0, "frame served in idle");
        wr(`MLPC_OFS_CTRL_STATUS, 32'h0000_0006);
        wr(`MLPC_OFS_CTRL_STATUS, 32'h0000_0004);
        wait_lp(1'b0);
        repeat (10) @(posedge clk);
        chk(hold === 1'b1 && sent - s0 == 3, "hold not kept");
        wr(`MLPC_OFS_CTRL_STATUS, 32'h0000_0000);
        repeat (15) @(posedge clk);
        chk(sent - s0 == 4, "frame not resumed");
        $display("test drain done");
    endtask
    task automatic t_hold_req();
        s0 = sent;
        queue(3);
        wr(`MLPC_OFS_CTRL_STATUS, 32'h0000_0006);
        wait_lp(1'b1);
        chk(lpr === 1'b1 && sent - s0 == 1 && fifo === 1'b1,
            "queue drained");
        wr(`MLPC_OFS_CTRL_STATUS, 32'h0000_0004);
        wr(`MLPC_OFS_CTRL_STATUS, 32'h0000_0000);
        repeat (30) @(posedge clk);
        chk(sent - s0 == 3, "queue not resumed");
        $display("test hold request done");
    endtask
    task automatic t_auto();
        wr(`MLPC_OFS_IDLE_TIME, 32'h0000_0002);
        repeat (150) @(posedge clk);
        chk(lpr === 1'b0, "low power without auto");
        wr(`MLPC_OFS_CTRL_STATUS, 32'h0000_0001);
        wait_lp(1'b1);
        chk(lpr === 1'b1, "auto never entered");
        s0 = sent;
        queue(1);
        wait_lp(1'b0);
        chk(hold === 1'b1, "wake time not held");
        repeat (20) @(posedge clk);
        chk(sent - s0 == 1 && act === 1'b0, "frame after wake");
        wait_lp(1'b1);
        chk(n >= 60 && n <= 100, "idle duration");
        wr(`MLPC_OFS_CTRL_STATUS, 32'h0000_0000);
        wr(`MLPC_OFS_IDLE_TIME, 32'h0000_0000);
        wr(`MLPC_OFS_CTRL_STATUS, 32'h0000_0001);
        repeat (200) @(posedge clk);
        chk(lpr === 1'b0, "zero idle time entered");
        wr(`MLPC_OFS_CTRL_STATUS, 32'h0000_0000);
        $display("test auto done");
    endtask

    // ======================================================================
    // verdict, watchdog and main sequence
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // about 750 cycles expected; a wide margin against a slow design
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            print_verdict();
        end
    end
    initial begin
        srst = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 32'h0000_0000;
        {reg_write, reg_read, push, rx_lpi} = 4'h0;
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        t_regs();
        t_rx();
        t_drain();
        t_hold_req();
        t_auto();
        print_verdict();
    end
endmodule

// ===== mlpc_timer.sv
`timescale 1ns/1ps

module mlpc_timer (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // control
    input wire logic run,
    input wire logic tick,
    input wire logic [31:0] limit,
    // result
    output logic expired
);

    logic [31:0] count;

    // ======================================================================
    // counts limit plus one ticks, then stays expired until run drops
    always_ff @(posedge clk) begin
        if (srst || !run) begin
            count <= 32'h0000_0000;
            expired <= 1'b0;
        end else if (tick && !expired) begin
            if (count == limit) begin
                expired <= 1'b1;
            end else begin
                count <= count + 32'h0000_0001;
            end
        end
    end

endmodule
